/* File: core/capture_event_detector.sv */
/*
 * Edge or CAN message detector with capture prescaler.
 * Assumes level is already synchronous to clk_i and can_rx is a
 * one-cycle pulse from same-clock logic.
 */
`timescale 1ns/10ps
module capture_event_detector
    import capture_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    capture_if.det    cap
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic       prev_level;
        logic [3:0] presc;
        logic       event_hit;
    } det_state_t;

    det_state_t st_r;
    det_state_t st_nxt;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic       in_capture;
        logic       raw;
        logic [3:0] mask;
        in_capture = 1'b0;
        raw        = 1'b0;
        mask       = PRESC_MASK_1;
        st_nxt     = st_r;
        st_nxt.prev_level = cap.level;
        st_nxt.event_hit  = 1'b0;
        unique case (cap.mode)
            MODE_FALL: begin
                in_capture = 1'b1;
                raw = cap.can_en ? cap.can_rx
                                 : (st_r.prev_level && !cap.level); // see RULE_17
            end
            MODE_RISE: begin
                in_capture = 1'b1;
                raw = cap.can_en ? cap.can_rx
                                 : (!st_r.prev_level && cap.level); // see RULE_17
            end
            MODE_RISE_4: begin
                in_capture = 1'b1;
                mask = PRESC_MASK_4;
                raw = cap.can_en ? cap.can_rx
                                 : (!st_r.prev_level && cap.level); // see RULE_16
            end
            MODE_RISE_16: begin
                in_capture = 1'b1;
                mask = PRESC_MASK_16;
                raw = cap.can_en ? cap.can_rx
                                 : (!st_r.prev_level && cap.level); // see RULE_16
            end
            default: in_capture = 1'b0;
        endcase
        if (!in_capture) begin
            st_nxt.presc = 4'h0; // see RULE_09
        end else if (raw) begin
            // Count survives a prescale switch, so first hit may be early
            st_nxt.event_hit = ((st_r.presc & mask) == mask); // see RULE_10
            st_nxt.presc     = st_r.presc + 4'h1; // see RULE_02
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{prev_level: 1'b0, presc: 4'h0, event_hit: 1'b0}; // see RULE_09
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cap.event_hit = st_r.event_hit;

endmodule : capture_event_detector

/* File: core/timer_capture_unit.sv */
/*
 * Timer capture unit with classic Wishbone register slave.
 * Latches a selected 16-bit timer count on pin edges or CAN
 * message pulses. Assumes the timer counts and the CAN pulse come
 * from logic on clk_i; the capture pin is asynchronous.
 */
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps

// Behaviour
// RULE_01: Each capture event copies the full 16-bit selected timer count into the value pair.
// RULE_02: Events are falling edge, rising edge, every fourth or every sixteenth rising edge.
// RULE_03: The four-bit mode field in the control register low bits picks event and prescale.
// RULE_04: A capture sets the capture flag at bit 1 of the flag register; only software clears it.
// RULE_05: A new capture overwrites the held value even if software has not read it.
// RULE_06: Software runs the capture timer in timer or synchronized counter mode.
// RULE_07: The time base is timer one or timer three, chosen in the timer three control register.
// RULE_08: Software keeps the capture interrupt masked while changing mode and clears the flag after.
// RULE_09: The prescaler clears whenever the unit is off or not in capture mode, and on reset.
// RULE_10: Switching straight between prescale settings keeps the count, so a capture may come early.
// RULE_11: Software writes zero to the control register before writing a new prescale mode.
// RULE_12: With the pin set as output, a port write making the selected edge triggers a capture.
// RULE_13: For pin capture software sets the pin direction bit to input.
// RULE_14: With the CAN time-stamp bit (bit 4 of CAN I/O control) set, message pulses replace the pin.
// RULE_15: In time-stamp mode a message stored in any receive buffer triggers a capture.
// RULE_16: In time-stamp mode codes 0100 and 0101 take every message, 0110 every 4th, 0111 every 16th.
// RULE_17: Pin codes 0100 fall, 0101 rise, 0110 every 4th rise, 0111 every 16th rise; pin synchronized first.
module timer_capture_unit
    import capture_pkg::*;
#(
    parameter int TIMER_W   = 16,
    parameter int RX_BUFS   = 3
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Wishbone classic slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Time bases
    input  wire logic [TIMER_W-1:0] timer_one_count_i,
    input  wire logic [TIMER_W-1:0] timer_three_count_i,
    // CAN receive buffers, one store pulse each
    input  wire logic [RX_BUFS-1:0] can_msg_stored_i,
    // Capture pin, split into three signals
    input  wire logic               capture_input_pin_i,
    output logic                    capture_pin_out_o,
    output logic                    capture_pin_oe_o,
    // Interrupt
    output logic                    irq_o
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [1:0]         pin_sync;
        logic [3:0]         mode;
        logic [TIMER_W-1:0] capture;
        logic               irq_flag;
        logic               irq_enable;
        logic               timer_sel;
        logic               can_ts_en;
        logic               pin_dir;
        logic               pin_latch;
        logic               pin_oe;
        logic               can_rx;
        logic               ack;
        logic [31:0]        rdata;
        logic               irq;
    } top_state_t;

    localparam top_state_t TOP_RESET = '{
        pin_sync:   2'h0,
        mode:       MODE_RESET,
        capture:    TIMER_W'(CAPTURE_RESET),
        irq_flag:   1'b0,
        irq_enable: 1'b0,
        timer_sel:  1'b0,
        can_ts_en:  1'b0,
        pin_dir:    PIN_DIR_RESET,
        pin_latch:  PIN_LATCH_RESET,
        pin_oe:     !PIN_DIR_RESET,
        can_rx:     1'b0,
        ack:        1'b0,
        rdata:      32'h0000_0000,
        irq:        1'b0
    };

    top_state_t st_r;
    top_state_t st_nxt;

    // ==========================================================
    // Event detector
    // ==========================================================
    capture_if cap ();

    // Output latch loops back when the pin drives, so port writes
    // can trigger captures on their own
    assign cap.level  = st_r.pin_dir ? st_r.pin_sync[1]
                                     : st_r.pin_latch; // see RULE_12
    assign cap.can_rx = st_r.can_rx;
    assign cap.can_en = st_r.can_ts_en; // see RULE_14
    assign cap.mode   = st_r.mode; // see RULE_03

    capture_event_detector u_detector (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cap   (cap)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic        access;
        logic        wr;
        logic [7:0]  wbyte;
        logic [31:0] rd;
        access = 1'b0;
        wr     = 1'b0;
        wbyte  = 8'h00;
        rd     = 32'h0000_0000;
        st_nxt = st_r;

        // Pin through two flops before any logic looks at it
        st_nxt.pin_sync = {st_r.pin_sync[0], capture_input_pin_i}; // see RULE_17

        // Any receive buffer storing a message counts
        st_nxt.can_rx = |can_msg_stored_i; // see RULE_15

        // Bus: one wait cycle, ack for one cycle only
        access = wb_cyc_i && wb_stb_i && !st_r.ack;
        wr     = access && wb_we_i && wb_sel_i[0];
        wbyte  = wb_dat_i[7:0];
        st_nxt.ack = access;

        unique case (wb_adr_i)
            OFS_CAPTURE_CONTROL: rd[MODE_W-1:0] = st_r.mode;
            OFS_CAPTURE_LOW:     rd[7:0] = st_r.capture[7:0];
            OFS_CAPTURE_HIGH:    rd[7:0] = st_r.capture[TIMER_W-1:8];
            OFS_IRQ_STATUS:      rd[IRQ_CAPTURE_BIT] = st_r.irq_flag;
            OFS_IRQ_MASK:        rd[IRQ_CAPTURE_BIT] = st_r.irq_enable;
            OFS_TIMER_THREE_CTL: rd[TIMER_SEL_BIT] = st_r.timer_sel;
            OFS_CAN_IO_CONTROL:  rd[CAN_TS_BIT] = st_r.can_ts_en;
            OFS_PIN_CONTROL: begin
                rd[PIN_DIR_BIT]   = st_r.pin_dir;
                rd[PIN_LATCH_BIT] = st_r.pin_latch;
            end
            default:             rd = 32'h0000_0000;
        endcase
        st_nxt.rdata = access ? rd : 32'h0000_0000;

        if (wr) begin
            unique case (wb_adr_i)
                OFS_CAPTURE_CONTROL:
                    st_nxt.mode = wbyte[MODE_W-1:0]; // see RULE_03
                OFS_IRQ_STATUS:
                    if (wbyte[IRQ_CAPTURE_BIT]) begin
                        st_nxt.irq_flag = 1'b0;
                    end
                OFS_IRQ_MASK:
                    st_nxt.irq_enable = wbyte[IRQ_CAPTURE_BIT];
                OFS_TIMER_THREE_CTL:
                    st_nxt.timer_sel = wbyte[TIMER_SEL_BIT]; // see RULE_07
                OFS_CAN_IO_CONTROL:
                    st_nxt.can_ts_en = wbyte[CAN_TS_BIT]; // see RULE_14
                OFS_PIN_CONTROL: begin
                    st_nxt.pin_dir   = wbyte[PIN_DIR_BIT];
                    st_nxt.pin_latch = wbyte[PIN_LATCH_BIT]; // see RULE_12
                end
                default: st_nxt.mode = st_r.mode;
            endcase
        end

        // Capture after the bus so a capture beats a same-cycle clear
        if (cap.event_hit) begin
            st_nxt.capture  = st_r.timer_sel ? timer_three_count_i
                                             : timer_one_count_i; // see RULE_01
            st_nxt.irq_flag = 1'b1; // see RULE_04
        end
        // Value simply overwritten, no overrun kept: see RULE_05

        st_nxt.irq = st_nxt.irq_flag && st_nxt.irq_enable;

        // Direction bit set means input, so drive only when clear
        st_nxt.pin_oe = !st_nxt.pin_dir;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= TOP_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign wb_dat_o          = st_r.rdata;
    assign wb_ack_o          = st_r.ack;
    assign capture_pin_out_o = st_r.pin_latch;
    assign capture_pin_oe_o  = st_r.pin_oe;
    assign irq_o             = st_r.irq;

endmodule : timer_capture_unit

/* File: shared/capture_if.sv */
/*
 * Carrier between the capture unit top and its event detector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface capture_if;
    logic       level;
    logic       can_rx;
    logic       can_en;
    logic [3:0] mode;
    logic       event_hit;

    modport top (
        output level,
        output can_rx,
        output can_en,
        output mode,
        input  event_hit
    );

    modport det (
        input  level,
        input  can_rx,
        input  can_en,
        input  mode,
        output event_hit
    );
endinterface : capture_if

/* File: shared/capture_pkg.sv */
/*
 * Constants for the timer capture unit: register offsets, field
 * positions, reset values and capture mode codes.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package capture_pkg;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] OFS_CAPTURE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CAPTURE_LOW     = 8'h04;
    localparam logic [7:0] OFS_CAPTURE_HIGH    = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS      = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK        = 8'h10;
    localparam logic [7:0] OFS_TIMER_THREE_CTL = 8'h14;
    localparam logic [7:0] OFS_CAN_IO_CONTROL  = 8'h18;
    localparam logic [7:0] OFS_PIN_CONTROL     = 8'h1C;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int MODE_LSB        = 0;
    localparam int MODE_W          = 4;
    localparam int IRQ_CAPTURE_BIT = 1;
    localparam int TIMER_SEL_BIT   = 0;
    localparam int CAN_TS_BIT      = 4;
    localparam int PIN_DIR_BIT     = 0;
    localparam int PIN_LATCH_BIT   = 1;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [3:0]  MODE_RESET      = 4'h0;
    localparam logic [15:0] CAPTURE_RESET   = 16'h0000;
    localparam logic        PIN_DIR_RESET   = 1'b1;
    localparam logic        PIN_LATCH_RESET = 1'b0;

    // ==========================================================
    // Capture mode codes
    // ==========================================================
    typedef enum logic [3:0] {
        MODE_OFF      = 4'h0,
        MODE_FALL     = 4'h4,
        MODE_RISE     = 4'h5,
        MODE_RISE_4   = 4'h6,
        MODE_RISE_16  = 4'h7
    } capture_mode_t;

    localparam logic [3:0] PRESC_MASK_1  = 4'h0;
    localparam logic [3:0] PRESC_MASK_4  = 4'h3;
    localparam logic [3:0] PRESC_MASK_16 = 4'hF;

endpackage : capture_pkg

/* File: sim/capture_source_model.sv */
/* Far side of the unit: capture pin driver and CAN store pulses.
   Assumes clk_i is the unit's clock. */
`timescale 1ns/10ps
module capture_source_model #(
    parameter int BUFS = 3
) (
    input  wire logic      clk_i,
    output logic           pin_o,
    output logic [BUFS-1:0] can_o
);
    initial begin
        pin_o = 1'b0;
        can_o = '0;
    end
    // Long levels so the pin survives the two-flop synchronizer
    task automatic pulse_pin();
        repeat (4) @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        pin_o <= 1'b0;
    endtask : pulse_pin
    task automatic pulse_can(input int b);
        @(posedge clk_i);
        can_o <= BUFS'(1) << b;
        @(posedge clk_i);
        can_o <= '0;
    endtask : pulse_can
endmodule : capture_source_model

/* File: sim/timer_capture_unit_props.sv */
/* Port checker for timer_capture_unit, bound into each instance.
   Assumes the master releases its request after every ack. */
`timescale 1ns/10ps
module timer_capture_unit_props
    import capture_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        capture_pin_out_o,
    input wire logic        capture_pin_oe_o,
    input wire logic        irq_o
);
    logic wr;
    logic pin_wr;
    assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign pin_wr = wr && wb_sel_i[0] && wb_adr_i == OFS_PIN_CONTROL;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_pulse; endproperty
    property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    property p_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_map;
        s_req ##0 (wb_adr_i[1:0] != 2'h0 || wb_adr_i > OFS_PIN_CONTROL)
            |=> wb_dat_o == 32'h0;
    endproperty
    // Only a write can drop the flag or its mask
    property p_irq; irq_o && !wr && !$past(wr) |=> irq_o; endproperty
    property p_rst;
        $fell(rst_i) |-> !wb_ack_o && !irq_o && !capture_pin_oe_o
            && !capture_pin_out_o;
    endproperty
    property p_oe;
        $changed(capture_pin_oe_o) |-> $past(pin_wr) || $past(pin_wr, 2);
    endproperty
    property p_out;
        $changed(capture_pin_out_o) |-> $past(pin_wr) || $past(pin_wr, 2);
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    a_idle: assert property (p_idle) else $error("stray ack");
    a_zero: assert property (p_zero) else $error("data held");
    a_map: assert property (p_map) else $error("unmapped data");
    a_irq: assert property (p_irq) else $error("irq dropped");
    a_rst: assert property (p_rst) else $error("reset state");
    a_oe: assert property (p_oe) else $error("oe moved");
    a_out: assert property (p_out) else $error("out moved");
endmodule : timer_capture_unit_props

bind timer_capture_unit timer_capture_unit_props i_props (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .capture_pin_out_o, .capture_pin_oe_o, .irq_o);

/* File: sim/timer_capture_unit_test.sv */
/* Self-checking bench for timer_capture_unit with a scoreboard model.
   Assumes the source model drives the pin and CAN store pulses. */
`timescale 1ns/10ps
module timer_capture_unit_test;
    import capture_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, ack, irq, pout, poe, pin;
    logic [7:0]  adr = 8'h00;
    logic [31:0] di = 32'h0, dout, q;
    logic [15:0] t1 = 16'h0, t3 = 16'h0;
    logic [2:0]  can;
    logic [3:0]  sel = 4'hF, wsel = 4'hF;
    int          n_fail = 0, checks = 0, cnt = 0, flag = 0, capv = 0;
    int          msk = 0, md = 0, tsel = 0;
    always #2 clk_i = ~clk_i;
    capture_source_model i_src (.clk_i(clk_i), .pin_o(pin), .can_o(can));
    timer_capture_unit i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack),
        .timer_one_count_i(t1), .timer_three_count_i(t3),
        .can_msg_stored_i(can), .capture_input_pin_i(pin),
        .capture_pin_out_o(pout), .capture_pin_oe_o(poe), .irq_o(irq));
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        di <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && k++ < 50);
        n_fail += (k > 50);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(logic [7:0] a, logic [31:0] e, string n);
        wb(1'b0, a, 32'h0);
        chk(n, q, e);
    endtask : rd
    task automatic mode(int m);
        wb(1'b1, OFS_CAPTURE_CONTROL, 32'(m));
        md = m;
        if (m < 4)
            cnt = 0;
    endtask : mode
    // Fires when the count before this event fills the mask
    task automatic ev(int src);
        int mk;
        mk = (md == 6) ? 3 : (md == 7) ? 15 : 0;
        if (src == 0)
            i_src.pulse_pin();
        else if (src == 1)
            i_src.pulse_can($urandom % 3);
        repeat (6) @(posedge clk_i);
        if ((cnt & mk) == mk) begin
            flag = 1;
            capv = tsel ? t3 : t1;
        end
        cnt++;
    endtask : ev
    task automatic verify();
        rd(OFS_IRQ_STATUS, 32'(flag) << 1, "flag");
        rd(OFS_CAPTURE_LOW, capv & 255, "low");
        rd(OFS_CAPTURE_HIGH, capv >> 8, "high");
        chk("irq", irq, 32'(flag != 0 && msk != 0));
    endtask : verify
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(79));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CAPTURE_CONTROL, 32'h0, "control");
        rd(OFS_IRQ_STATUS, 32'h0, "flag");
        rd(OFS_PIN_CONTROL, 32'h1, "pin");
        rd(8'h20, 32'h0, "unmapped");
        $display("reset test done");
        for (int s = 0; s < 2; s++) begin
            wb(1'b1, OFS_CAN_IO_CONTROL, 32'(s) << CAN_TS_BIT);
            for (int m = 4; m < 8; m++) begin
                wb(1'b1, OFS_IRQ_MASK, 32'h0);
                mode(0);
                mode(m);
                msk = ($urandom % 2) * 2;
                tsel = $urandom % 2;
                wb(1'b1, OFS_IRQ_MASK, 32'(msk));
                wb(1'b1, OFS_TIMER_THREE_CTL, 32'(tsel));
                wb(1'b1, OFS_IRQ_STATUS, 32'h2);
                flag = 0;
                repeat (2) begin
                    t1 <= 16'($urandom);
                    t3 <= 16'($urandom);
                    if (s == 1)
                        i_src.pulse_pin();
                    repeat ((m == 6) ? 4 : (m == 7) ? 16 : 1) ev(s);
                    verify();
                end
            end
            $display("source %0d test done", s);
        end
        mode(0);
        mode(6);
        wb(1'b1, OFS_IRQ_STATUS, 32'h2);
        flag = 0;
        repeat (2) ev(1);
        mode(7);
        t1 <= 16'($urandom);
        repeat (14) ev(1);
        verify();
        wb(1'b1, OFS_CAN_IO_CONTROL, 32'h0);
        mode(0);
        mode(5);
        wb(1'b1, OFS_PIN_CONTROL, 32'h0);
        wb(1'b1, OFS_IRQ_STATUS, 32'h2);
        flag = 0;
        wb(1'b1, OFS_PIN_CONTROL, 32'h2);
        ev(2);
        verify();
        chk("oe", poe, 32'h1);
        chk("out", pout, 32'h1);
        wb(1'b1, 8'h20, 32'hFF);
        // Write with byte lane 0 off must leave the mode alone
        wsel = 4'h0;
        wb(1'b1, OFS_CAPTURE_CONTROL, 32'h0);
        wsel = 4'hF;
        rd(OFS_CAPTURE_CONTROL, 32'h5, "control");
        $display("switch and port test done");
        complete_run();
    end
endmodule : timer_capture_unit_test
